// file: src/battery_charger_control.sv
/*
 * Battery charger control: control and setting registers, charger state machine, interrupt flags
 * and sense bits, reached as a classic Wishbone slave.
 * Assumes the analog comparators and fault detectors arrive already synchronous to clk_i, and
 * that the analog loops act on the codes driven out.
 */

module battery_charger_control (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic usb_source_i,
    input chg_pkg::analog_t analog_i,
    output chg_pkg::drive_t drive_o,
    output logic irq_o
);

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_PRECHARGE,
        ST_CHARGE,
        ST_DONE,
        ST_FAULT
    } chg_state_t;

    // ************************************************************
    // Wishbone slave.
    // ************************************************************
    logic access;
    logic wr;
    logic [13:0] ctrl;
    logic [7:0] setting;
    logic [chg_pkg::NUM_IRQ-1:0] irq_flag;
    logic [chg_pkg::NUM_IRQ-1:0] irq_mask;
    logic [chg_pkg::NUM_IRQ-1:0] irq_event;
    logic [1:0] fault_sense;
    logic restart_pulse;
    chg_state_t state;
    chg_state_t next_state;
    logic [2:0] eff_vcode;
    logic [3:0] eff_icode;
    logic prev_attach;
    logic prev_usbov;
    logic prev_short;
    logic prev_curr;
    logic prev_wall;
    logic prev_cycl;
    logic any_fault;
    logic wr_ctrl;
    logic wr_setting;
    logic wr_irq;
    logic wr_mask;
    logic [31:0] ctrl_merged;
    logic [31:0] sense_word;

    assign access = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr = access && wb_we_i;

    // One strobe per register, raised in the cycle in which a write is taken.
    assign wr_ctrl = wr && wb_adr_i == chg_pkg::CTRL_OFS;
    assign wr_setting = wr && wb_adr_i == chg_pkg::SETTING_OFS && wb_sel_i[0];
    assign wr_irq = wr && wb_adr_i == chg_pkg::IRQ_OFS && wb_sel_i[0];
    assign wr_mask = wr && wb_adr_i == chg_pkg::MASK_OFS && wb_sel_i[0];

    // Merges one write into a register according to the byte enables.
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                          input logic [3:0] sel);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                res[i*8 +: 8] = data[i*8 +: 8];
            end
        end
        return res;
    endfunction

    assign ctrl_merged = merge({18'h00000, ctrl}, wb_dat_i, wb_sel_i);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= access;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl <= {chg_pkg::POWER_LIMIT_SELECT_RESET, 12'h000};
        end else if (wr_ctrl) begin
            ctrl <= ctrl_merged[13:0];
            ctrl[chg_pkg::RESTART_BIT] <= 1'b0;
        end
    end

    // Restart is a write-one strobe; the stored bit always reads zero.
    assign restart_pulse = wr && wb_adr_i == chg_pkg::CTRL_OFS && wb_sel_i[0]
                           && wb_dat_i[chg_pkg::RESTART_BIT];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            setting <= {chg_pkg::ISEL_RESET, 1'b0, chg_pkg::VSEL_RESET};
        end else if (wr_setting) begin
            setting <= wb_dat_i[7:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_mask <= '1;
        end else if (wr_mask) begin
            irq_mask <= wb_dat_i[chg_pkg::NUM_IRQ-1:0];
        end
    end

    // ************************************************************
    // Read path.
    // ************************************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= 32'h00000000;
        end else if (access && !wb_we_i) begin
            case (wb_adr_i)
                chg_pkg::CTRL_OFS: wb_dat_o <= {18'h00000, ctrl};
                chg_pkg::SETTING_OFS: wb_dat_o <= {24'h000000, setting};
                chg_pkg::IRQ_OFS: wb_dat_o <= {24'h000000, irq_flag};
                chg_pkg::MASK_OFS: wb_dat_o <= {24'h000000, irq_mask};
                chg_pkg::SENSE_OFS: wb_dat_o <= sense_word;
                chg_pkg::DECODE_OFS: wb_dat_o <= {8'h00,
                    chg_pkg::CUR_MA[eff_icode], chg_pkg::VOLT_MV[eff_vcode]};
                default: wb_dat_o <= 32'h00000000;
            endcase
        end
    end

    function automatic logic [2:0] chg_state_code(input chg_state_t s);
        return 3'(s);
    endfunction

    // Status word: fault mode, charger enabled, wall pin, wiring and state code.
    always_comb begin
        sense_word = 32'h00000000;
        sense_word[1:0] = fault_sense;
        sense_word[2] = drive_o.charger_enabled;
        sense_word[3] = analog_i.wall_charger_detect_pin;
        sense_word[4] = analog_i.serial_path;
        sense_word[7:5] = chg_state_code(state);
    end

    // ************************************************************
    // Charger state machine.
    // ************************************************************
    assign any_fault = analog_i.over_voltage || analog_i.power_excess || analog_i.timeout
                       || (analog_i.temp_range && !ctrl[chg_pkg::THERM_BIT]);

    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (analog_i.attach) begin
                    next_state = ST_PRECHARGE;
                end
            end
            ST_PRECHARGE: begin
                if (analog_i.battery_min_comparator) begin
                    next_state = ST_CHARGE;
                end
            end
            ST_CHARGE: begin
                if (analog_i.charge_done || !analog_i.charge_current_comparator) begin
                    next_state = ST_DONE;
                end else if (!analog_i.battery_min_comparator) begin
                    next_state = ST_PRECHARGE;
                end
            end
            ST_DONE: begin
                if (!ctrl[chg_pkg::CYCL_BIT] && !analog_i.recharge_cycle_comparator) begin
                    next_state = ST_CHARGE;
                end
            end
            ST_FAULT: begin
                if (!any_fault) begin
                    next_state = ST_PRECHARGE;
                end
            end
            default: next_state = ST_IDLE;
        endcase
        if (!analog_i.attach) begin
            next_state = ST_IDLE;
        end else if (any_fault) begin
            next_state = ST_FAULT;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || restart_pulse) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fault_sense <= 2'h0;
        end else if (analog_i.over_voltage || analog_i.power_excess) begin
            fault_sense <= chg_pkg::FAULT_OV_PWR;
        end else if (analog_i.timeout) begin
            fault_sense <= chg_pkg::FAULT_TIMEOUT;
        end else if (analog_i.temp_range && !ctrl[chg_pkg::THERM_BIT]) begin
            fault_sense <= chg_pkg::FAULT_TEMP;
        end else if (state != ST_FAULT) begin
            fault_sense <= 2'h0;
        end
    end

    // ************************************************************
    // Effective settings and drives.
    // ************************************************************
    always_comb begin
        eff_vcode = setting[chg_pkg::VSEL_LSB +: 3];
        eff_icode = setting[chg_pkg::ISEL_LSB +: 4];
        if (!ctrl[chg_pkg::SWCHG_BIT] && !ctrl[chg_pkg::ALLOW_BIT]) begin
            eff_vcode = chg_pkg::VSEL_RESET;
            if (state == ST_PRECHARGE || usb_source_i) begin
                eff_icode = chg_pkg::ISEL_LOW_DEFAULT;
            end else begin
                eff_icode = chg_pkg::ISEL_STD_DEFAULT;
            end
        end
        if (state == ST_IDLE || state == ST_DONE || state == ST_FAULT) begin
            eff_icode = chg_pkg::ISEL_OFF;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            drive_o <= '0;
        end else begin
            if (ctrl[chg_pkg::FETOV_BIT]) begin
                drive_o.battery_isolation_fet_drive <= !ctrl[chg_pkg::FETSW_BIT];
            end else begin
                drive_o.battery_isolation_fet_drive <= (eff_icode != chg_pkg::ISEL_FULL_ON)
                    && (!analog_i.serial_path || (analog_i.supply_rail_on_comparator
                    && analog_i.battery_on_comparator));
            end
            drive_o.reverse_supply_enable <= ctrl[chg_pkg::REV_BIT];
            drive_o.power_limiter_active <= !ctrl[chg_pkg::PLDIS_BIT] && !ctrl[chg_pkg::REV_BIT];
            drive_o.charge_led_output <= ctrl[chg_pkg::LED_BIT]
                && (state == ST_CHARGE || state == ST_PRECHARGE);
            drive_o.charger_enabled <= eff_icode != chg_pkg::ISEL_OFF;
            drive_o.therm_check_enable <= !ctrl[chg_pkg::THERM_BIT];
            drive_o.current_step_up <= analog_i.battery_min_comparator;
            drive_o.voltage_code <= eff_vcode;
            drive_o.current_code <= eff_icode;
            drive_o.power_limit_select <= ctrl[chg_pkg::POWER_LIMIT_SELECT_LSB +: 2];
        end
    end

    // ************************************************************
    // Interrupt flags: set wins over a write-one clear.
    // ************************************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            {prev_attach, prev_usbov, prev_short, prev_curr, prev_wall, prev_cycl} <= 6'h00;
        end else begin
            prev_attach <= analog_i.attach;
            prev_usbov <= analog_i.usb_over_voltage;
            prev_short <= analog_i.reverse_short;
            prev_curr <= analog_i.charge_current_comparator;
            prev_wall <= analog_i.wall_charger_detect_pin;
            prev_cycl <= analog_i.recharge_cycle_comparator;
        end
    end

    always_comb begin
        irq_event = '0;
        irq_event[chg_pkg::IRQ_ATTACH] = analog_i.attach != prev_attach;
        irq_event[chg_pkg::IRQ_FAULT] = any_fault && state != ST_FAULT;
        irq_event[chg_pkg::IRQ_USBOV] = analog_i.usb_over_voltage && !prev_usbov;
        irq_event[chg_pkg::IRQ_SHORT] = analog_i.reverse_short && !prev_short
                                        && ctrl[chg_pkg::REV_BIT];
        irq_event[chg_pkg::IRQ_REVCUR] = !analog_i.charge_current_comparator && prev_curr
                                         && ctrl[chg_pkg::REV_BIT];
        irq_event[chg_pkg::IRQ_CURTHR] = analog_i.charge_current_comparator != prev_curr;
        irq_event[chg_pkg::IRQ_REGMODE] = analog_i.recharge_cycle_comparator != prev_cycl;
        irq_event[chg_pkg::IRQ_WALL] = analog_i.wall_charger_detect_pin != prev_wall;
    end

    for (genvar g = 0; g < chg_pkg::NUM_IRQ; g++) begin : g_flag
        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                irq_flag[g] <= 1'b0;
            end else if (irq_event[g]) begin
                irq_flag[g] <= 1'b1;
            end else if (wr_irq && wb_dat_i[g]) begin
                irq_flag[g] <= 1'b0;
            end
        end
    end

    // ************************************************************
    // Interrupt output.
    // ************************************************************
    // A level: it stays up until software clears the flag or masks it.
    assign irq_o = |(irq_flag & ~irq_mask);

endmodule

// file: src/chg_pkg.sv
/*
 * Package for the battery charger control block: register offsets, field positions, reset values,
 * code tables and the carrier structs used by the block.
 * Assumes a classic Wishbone slave with 32-bit data and byte addresses.
 */
package chg_pkg;

    // ************************************************************
    // Register byte offsets.
    // ************************************************************
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] SETTING_OFS = 8'h04;
    localparam logic [7:0] IRQ_OFS = 8'h08;
    localparam logic [7:0] MASK_OFS = 8'h0c;
    localparam logic [7:0] SENSE_OFS = 8'h10;
    localparam logic [7:0] DECODE_OFS = 8'h14;

    // ************************************************************
    // Control register field positions.
    // ************************************************************
    localparam int FETOV_BIT = 0;
    localparam int FETSW_BIT = 1;
    localparam int REV_BIT = 2;
    localparam int PLDIS_BIT = 3;
    localparam int LED_BIT = 4;
    localparam int RESTART_BIT = 5;
    localparam int SWCHG_BIT = 6;
    localparam int ALLOW_BIT = 7;
    localparam int CYCL_BIT = 8;
    localparam int THERM_BIT = 9;
    localparam int POWER_LIMIT_SELECT_LSB = 10;

    // ************************************************************
    // Setting register field positions and reset values.
    // ************************************************************
    localparam int VSEL_LSB = 0;
    localparam int ISEL_LSB = 4;
    localparam logic [2:0] VSEL_RESET = 3'h3;
    localparam logic [3:0] ISEL_RESET = 4'h0;
    localparam logic [1:0] POWER_LIMIT_SELECT_RESET = 2'h0;
    localparam logic [3:0] ISEL_OFF = 4'h0;
    localparam logic [3:0] ISEL_FULL_ON = 4'hf;
    localparam logic [3:0] ISEL_LOW_DEFAULT = 4'h1;
    localparam logic [3:0] ISEL_STD_DEFAULT = 4'h6;
    localparam logic [1:0] FAULT_OV_PWR = 2'h1;
    localparam logic [1:0] FAULT_TIMEOUT = 2'h2;
    localparam logic [1:0] FAULT_TEMP = 2'h3;

    // ************************************************************
    // Interrupt flag positions.
    // ************************************************************
    localparam int NUM_IRQ = 8;
    localparam int IRQ_ATTACH = 0;
    localparam int IRQ_FAULT = 1;
    localparam int IRQ_USBOV = 2;
    localparam int IRQ_SHORT = 3;
    localparam int IRQ_REVCUR = 4;
    localparam int IRQ_CURTHR = 5;
    localparam int IRQ_REGMODE = 6;
    localparam int IRQ_WALL = 7;

    // ************************************************************
    // Code tables: millivolts, milliamps and milliwatts.
    // ************************************************************
    localparam logic [12:0] VOLT_MV [8] = '{13'd3800, 13'd4100, 13'd4150, 13'd4200,
                                            13'd4250, 13'd4300, 13'd4375, 13'd4450};
    localparam logic [10:0] CUR_MA [16] = '{11'd0, 11'd80, 11'd240, 11'd320, 11'd400, 11'd480,
                                            11'd560, 11'd640, 11'd720, 11'd800, 11'd880, 11'd960,
                                            11'd1040, 11'd1200, 11'd1600, 11'd0};
    localparam logic [10:0] PWR_MW [4] = '{11'd600, 11'd800, 11'd1000, 11'd1200};

    // ************************************************************
    // Carrier structs.
    // ************************************************************
    typedef struct packed {
        logic over_voltage;
        logic power_excess;
        logic timeout;
        logic temp_range;
        logic attach;
        logic usb_over_voltage;
        logic reverse_short;
        logic charge_current_comparator;
        logic battery_min_comparator;
        logic supply_rail_on_comparator;
        logic battery_on_comparator;
        logic recharge_cycle_comparator;
        logic wall_charger_detect_pin;
        logic serial_path;
        logic charge_done;
    } analog_t;

    typedef struct packed {
        logic battery_isolation_fet_drive;
        logic reverse_supply_enable;
        logic power_limiter_active;
        logic charge_led_output;
        logic charger_enabled;
        logic therm_check_enable;
        logic current_step_up;
        logic [2:0] voltage_code;
        logic [3:0] current_code;
        logic [1:0] power_limit_select;
    } drive_t;

endpackage

// file: tb/analog_model.sv
/*
 * Model of the analog front end that feeds the charger control block.
 * Assumes the bench asks for detector levels; they reach the block one clock later.
 */
module analog_model (
    input wire logic clk_i,
    input wire chg_pkg::analog_t req_i,
    output chg_pkg::analog_t analog_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // Retiming keeps the levels synchronous to the block clock.
    always @(posedge clk_i) begin
        analog_o <= req_i;
    end
endmodule

// file: tb/battery_charger_control_sva.sv
/*
 * Checker for the charger control block, tracking register writes from the bus.
 * Assumes all byte lanes are enabled on every write.
 */
module chg_checker (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic wb_ack_o,
    input wire chg_pkg::drive_t drive_o,
    input wire logic irq_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [11:0] ctl;
    logic [7:0] cfg;
    logic [7:0] msk;
    logic live;
    logic sa;
    assign sa = !ctl[6] && !ctl[7];
    // Shadows update at the edge that sees ack, when the drives also catch up.
    always_ff @(posedge clk_i) begin
        live <= !rst_i;
        if (rst_i) begin
            ctl <= 12'h000;
            cfg <= 8'h03;
            msk <= 8'hff;
        end else if (wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o) begin
            if (wb_adr_i == chg_pkg::CTRL_OFS) ctl <= wb_dat_i[11:0];
            if (wb_adr_i == chg_pkg::SETTING_OFS) cfg <= wb_dat_i[7:0];
            if (wb_adr_i == chg_pkg::MASK_OFS) msk <= wb_dat_i[7:0];
        end
    end
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    AST_FET_OVR: assert property (live && ctl[0] |-> drive_o.battery_isolation_fet_drive == !ctl[1])
        else $error("fet drive ignores software level");
    AST_REV_EN: assert property (live |-> drive_o.reverse_supply_enable == ctl[2])
        else $error("reverse supply mismatch");
    AST_LIMITER: assert property (live |-> drive_o.power_limiter_active == (!ctl[3] && !ctl[2]))
        else $error("power limiter mismatch");
    AST_LED_OFF: assert property (live && !ctl[4] |-> !drive_o.charge_led_output)
        else $error("led driven while disabled");
    AST_THERM: assert property (live |-> drive_o.therm_check_enable == !ctl[9])
        else $error("thermistor check mismatch");
    AST_POWER_LIMIT_SELECT: assert property (live |-> drive_o.power_limit_select == ctl[11:10])
        else $error("power limit code mismatch");
    AST_VOLT: assert property (live |-> drive_o.voltage_code == (sa ? 3'h3 : cfg[2:0]))
        else $error("voltage code mismatch");
    AST_CUR_SA: assert property (live && sa |-> drive_o.current_code inside {4'h0, 4'h1, 4'h6})
        else $error("standalone current code out of set");
    AST_IRQ_MASK: assert property (live && (&msk) |-> !irq_o)
        else $error("interrupt seen while all masked");
    AST_ACK_PULSE: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
        else $error("ack not a one cycle answer");
    cover property (ctl[0] && ctl[1]);
    cover property (wb_ack_o && !wb_we_i && wb_adr_i == chg_pkg::SENSE_OFS);
    cover property (irq_o && !sa);
endmodule

bind battery_charger_control chg_checker chg_checker_inst (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_adr_i, .wb_dat_i, .wb_ack_o, .drive_o, .irq_o);

// file: tb/battery_charger_control_tb.sv
/*
 * Bench for the charger control block: bus tasks, LFSR driven register traffic, events.
 * Assumes the analog model retimes detector levels by one clock.
 */
module battery_charger_control_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'hf;
    logic [31:0] wdat = 32'h0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic usb = 1'b0;
    logic irq_o;
    chg_pkg::analog_t areq = '0;
    chg_pkg::analog_t analog;
    chg_pkg::drive_t drv;
    logic [31:0] lfsr = 32'hc06e32eb;
    logic [31:0] rd;
    logic [11:0] c;
    logic [7:0] s;
    logic [12:0] mvt [8] = '{13'd3800, 13'd4100, 13'd4150, 13'd4200, 13'd4250, 13'd4300, 13'd4375, 13'd4450};
    int ab [7] = '{10, 9, 7, 3, 2, 14, 8};
    int ib [7] = '{0, 2, 5, 6, 7, 1, 3};
    int error_cnt = 0;
    int cmp_count = 0;

    initial begin
        forever #20 clk_i = ~clk_i;
    end

    analog_model analog_model_inst (.clk_i, .req_i(areq), .analog_o(analog));
    battery_charger_control battery_charger_control_inst (.clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o, .wb_ack_o,
        .usb_source_i(usb), .analog_i(analog), .drive_o(drv), .irq_o);

    task automatic end_sim;
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask

    function automatic logic [31:0] rnd();
        lfsr = {lfsr[30:0], 1'b0} ^ (lfsr[31] ? 32'h04c11db7 : 32'h0);
        return lfsr;
    endfunction

    function automatic logic [9:0] exp_drv(input logic [11:0] k, input logic [7:0] t);
        return {k[0] & ~k[1], k[2], ~k[3] & ~k[2], 1'b0, ~k[9], k[11:10], (k[6] | k[7]) ? t[2:0] : 3'h3};
    endfunction

    // Holds the request until ack is sampled, then idles one cycle.
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        rd = wb_dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (n >= 20) begin
            error_cnt++;
            end_sim();
        end
        @(posedge clk_i);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(rd, e);
    endtask

    task automatic wirq(input logic v);
        int n;
        n = 0;
        while (irq_o !== v && n < 16) begin
            @(posedge clk_i);
            n++;
        end
        chk({31'h0, irq_o}, {31'h0, v});
        if (n >= 16) end_sim();
    endtask

    initial begin
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        rdc(chg_pkg::CTRL_OFS, 32'h0);
        rdc(chg_pkg::SETTING_OFS, 32'h3);
        rdc(chg_pkg::MASK_OFS, 32'hff);
        rdc(chg_pkg::IRQ_OFS, 32'h0);
        bus(1'b1, 8'h40, 32'hffffffff);
        rdc(8'h40, 32'h0);
        for (int i = 0; i < 24; i++) begin
            c = 12'(rnd());
            s = 8'(rnd()) & 8'hf7;
            usb <= lfsr[0];
            if (i < 8) c = {i[1:0], 3'h0, i[2], 4'h0, i[0], 1'b1};
            if (i < 8) s[2:0] = i[2:0];
            bus(1'b1, chg_pkg::CTRL_OFS, {20'h0, c});
            bus(1'b1, chg_pkg::SETTING_OFS, {24'h0, s});
            rdc(chg_pkg::CTRL_OFS, {20'h0, c & 12'hfdf});
            rdc(chg_pkg::SETTING_OFS, {24'h0, s});
            chk({22'h0, drv.battery_isolation_fet_drive & c[0], drv.reverse_supply_enable, drv.power_limiter_active,
                drv.charge_led_output & ~c[4], drv.therm_check_enable, drv.power_limit_select, drv.voltage_code},
                {22'h0, exp_drv(c, s)});
            bus(1'b0, chg_pkg::DECODE_OFS, 32'h0);
            chk({19'h0, rd[12:0]}, {19'h0, mvt[(c[6] | c[7]) ? s[2:0] : 3'h3]});
        end
        bus(1'b1, chg_pkg::CTRL_OFS, 32'h40);
        bus(1'b1, chg_pkg::SETTING_OFS, 32'h03);
        chk({28'h0, drv.current_code}, 32'h0);
        bus(1'b1, chg_pkg::SETTING_OFS, 32'h63);
        areq <= chg_pkg::analog_t'(15'h0006);
        @(posedge clk_i);
        bus(1'b0, chg_pkg::SENSE_OFS, 32'h0);
        chk({30'h0, rd[4:3]}, 32'h3);
        areq <= '0;
        @(posedge clk_i);
        bus(1'b0, chg_pkg::SENSE_OFS, 32'h0);
        chk({30'h0, rd[4:3]}, 32'h0);
        bus(1'b1, chg_pkg::CTRL_OFS, 32'h4);
        bus(1'b1, chg_pkg::IRQ_OFS, 32'hff);
        bus(1'b1, chg_pkg::MASK_OFS, 32'h0);
        for (int k = 0; k < 7; k++) begin
            areq <= chg_pkg::analog_t'(15'(1) << ab[k]);
            wirq(1'b1);
            bus(1'b0, chg_pkg::IRQ_OFS, 32'h0);
            chk({31'h0, rd[ib[k]]}, 32'h1);
            bus(1'b0, chg_pkg::SENSE_OFS, 32'h0);
            if (k == 5) chk({30'h0, rd[1:0]}, {30'h0, chg_pkg::FAULT_OV_PWR});
            areq <= '0;
            repeat (4) @(posedge clk_i);
            bus(1'b1, chg_pkg::IRQ_OFS, 32'hff);
            wirq(1'b0);
        end
        bus(1'b1, chg_pkg::MASK_OFS, 32'h1);
        areq.attach <= 1'b1;
        repeat (2) @(posedge clk_i);
        bus(1'b0, chg_pkg::IRQ_OFS, 32'h0);
        chk({31'h0, rd[0]}, 32'h1);
        chk({31'h0, irq_o}, 32'h0);
        bus(1'b1, chg_pkg::MASK_OFS, 32'h0);
        wirq(1'b1);
        usb <= 1'b0;
        areq.battery_min_comparator <= 1'b1;
        areq.charge_current_comparator <= 1'b1;
        repeat (4) @(posedge clk_i);
        chk({27'h0, drv.current_step_up, drv.current_code}, {27'h0, 1'b1, chg_pkg::ISEL_STD_DEFAULT});
        bus(1'b0, chg_pkg::SENSE_OFS, 32'h0);
        chk({29'h0, rd[7:5]}, 32'h2);
        chk({31'h0, rd[2]}, 32'h1);
        end_sim();
    end
endmodule
